// *** verilog/adcc_top.sv ***
// Purpose: Sample/convert control, result buffer and APB registers of the converter
// Assumes: Analog front end converts after conv_start_o and answers with conv_ready_i
// Notes:   Nothing below gates on sleep, so conversion carries on in sleep, and in idle unless idle-stop is set
//
// Notes on behaviour
// - Converter runs only while switched on
// - Switching off clears all buffered results
// - Idle-stop bit halts converter during idle
// - Four result formats from 10-bit code
// - Code 000: clearing sample bit starts conversion
// - Code 111: internal counter starts conversion
// - Pin edge, timer or charge event start
// - Auto-sample restarts sampling after each conversion
// - Without auto-sample, software starts sampling
// - Sample bit shows acquiring versus holding
// - Done bit set on finish, writable
// - Reference select drives reference switches
// - Sixteen result words held
// - Nine selectable channels: 0-5, 10-12
// - Keeps converting in sleep, and in idle unless idle-stop is set
// - Interrupt every N+1 sequences
// - Split mode fills two 8-word halves
// - Fill-half bit shows half being filled
// - Alternate mode: A first, then B/A
`timescale 1ns/100ps
module adcc_top
    import adcc_pkg::*;
#(
    parameter int unsigned SAMPLE_CYCLES = AUTO_SAMPLE_CYCLES
)
(
    // Clock, reset, enable
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             ce_i,
    // APB slave
    input  wire logic             psel_i,
    input  wire logic             penable_i,
    input  wire logic             pwrite_i,
    input  wire logic [7:0]       paddr_i,
    input  wire logic [31:0]      pwdata_i,
    output logic      [31:0]      prdata_o,
    output logic                  pready_o,
    output logic                  pslverr_o,
    // Device power state
    input  wire logic             idle_mode_i,
    // Trigger sources
    input  wire logic             external_irq_pin_zero_i,
    input  wire logic             timer_three_match_i,
    input  wire logic             charge_measure_unit_event_i,
    // Analog front end
    input  wire logic             conv_ready_i,
    input  wire logic [RES_W-1:0] conv_data_i,
    output logic                  conv_start_o,
    output logic                  sample_hold_o,
    output logic                  converter_on_o,
    output logic                  ref_plus_ext_o,
    output logic                  ref_minus_ext_o,
    output logic      [3:0]       mux_channel_o,
    output logic                  mux_b_select_o,
    // Event to the interrupt controller
    output logic                  converter_irq_flag_o
);
    import adcc_pkg::*;

    adcc_phase_t      phase_r;
    logic             converter_on_r;
    logic             converter_idle_stop_r;
    logic [1:0]       result_format_r;
    logic [2:0]       trigger_source_select_r;
    logic             auto_sample_start_r;
    logic             done_r;
    logic [2:0]       reference_select_r;
    logic [3:0]       sequences_per_irq_r;
    logic             split_buffer_mode_r;
    logic             alternate_mux_sample_r;
    logic [3:0]       chan_a_r;
    logic [3:0]       chan_b_r;
    logic [RES_W-1:0] buf_r [BUF_WORDS];
    logic [3:0]       wr_ptr_r;
    logic [3:0]       seq_cnt_r;
    logic             buffer_fill_half_r;
    logic             alt_phase_r;
    logic [15:0]      sample_enable_cnt_r;
    logic             conv_start_r;
    logic             irq_r;
    logic [31:0]      prdata_r;

    logic             wr_acc;
    logic             rd_setup;
    logic             wr_con1;
    logic             wr_con2;
    logic             wr_chsel;
    logic             mapped;
    logic             run;
    logic             sampling;
    logic             sw_end;
    logic             sw_start;
    logic             sw_abort;
    logic             trig_end;
    logic             end_sample;
    logic             complete;
    logic             count_done;
    logic [3:0]       wr_idx;
    logic [15:0]      fmt_word;
    logic [15:0]      con1_word;
    logic [15:0]      con2_word;
    logic [31:0]      rd_word;
    logic [3:0]       new_a;
    logic [3:0]       new_b;

    // APB decode; ce_i low stretches the access phase instead of losing it
    assign pready_o  = ce_i;
    assign wr_acc    = psel_i & penable_i & pwrite_i & ce_i;
    assign rd_setup  = psel_i & ~penable_i & ~pwrite_i & ce_i;
    assign mapped    = (paddr_i[1:0] == 2'h0) &&
                       ((paddr_i == OFF_CON1) || (paddr_i == OFF_CON2) ||
                        (paddr_i == OFF_CHSEL) || ((paddr_i & BUF_MASK) == OFF_BUF));
    assign pslverr_o = psel_i & penable_i & ~mapped;
    assign wr_con1   = wr_acc && (paddr_i == OFF_CON1);
    assign wr_con2   = wr_acc && (paddr_i == OFF_CON2);
    assign wr_chsel  = wr_acc && (paddr_i == OFF_CHSEL);
    assign prdata_o  = prdata_r;

    // Core control
    assign run        = converter_on_r & ~(converter_idle_stop_r & idle_mode_i)
                        & ce_i;
    assign sampling   = (phase_r == PH_SAMPLE);
    assign sw_end     = wr_con1 && !pwdata_i[CON1_SAMPLE_ENABLE] && sampling;
    assign sw_start   = wr_con1 && pwdata_i[CON1_SAMPLE_ENABLE] && (phase_r == PH_HOLD) && run;
    assign sw_abort   = sw_end && (trigger_source_select_r != TRIG_SW);
    assign count_done = (sample_enable_cnt_r == 16'(SAMPLE_CYCLES - 1));
    assign end_sample = run && sampling && trig_end;
    assign complete   = run && (phase_r == PH_CONVERT) && conv_ready_i;
    assign wr_idx     = split_buffer_mode_r ? {buffer_fill_half_r, wr_ptr_r[2:0]}
                                            : wr_ptr_r;

    adcc_trig_sel u_trig
    (
        .clk_i        (clk_i),
        .rst_n_i      (rst_n_i),
        .ce_i         (ce_i),
        .src_i        (trigger_source_select_r),
        .sw_end_i     (sw_end),
        .pin_i        (external_irq_pin_zero_i),
        .timer_i      (timer_three_match_i),
        .charge_i     (charge_measure_unit_event_i),
        .count_done_i (count_done),
        .end_o        (trig_end)
    );

    adcc_result_fmt u_fmt
    (
        .form_i (result_format_r),
        .raw_i  (buf_r[paddr_i[5:2]]),
        .word_o (fmt_word)
    );

    // Configuration registers
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            converter_on_r          <= CON1_RST[CON1_ON];
            converter_idle_stop_r   <= CON1_RST[CON1_SIDL];
            result_format_r         <= CON1_RST[CON1_FORM_LO +: 2];
            trigger_source_select_r <= CON1_RST[CON1_SRC_LO +: 3];
            auto_sample_start_r     <= CON1_RST[CON1_AUTO_SAMPLE_START];
            reference_select_r      <= CON2_RST[CON2_VCFG_LO +: 3];
            sequences_per_irq_r     <= CON2_RST[CON2_SMPI_LO +: 4];
            split_buffer_mode_r     <= CON2_RST[CON2_SPLIT_BUFFER_MODE];
            alternate_mux_sample_r  <= CON2_RST[CON2_ALTERNATE_MUX_SAMPLE];
        end
        else if (wr_con1)
        begin
            converter_on_r          <= pwdata_i[CON1_ON];
            converter_idle_stop_r   <= pwdata_i[CON1_SIDL];
            result_format_r         <= pwdata_i[CON1_FORM_LO +: 2];
            trigger_source_select_r <= pwdata_i[CON1_SRC_LO +: 3];
            auto_sample_start_r     <= pwdata_i[CON1_AUTO_SAMPLE_START];
        end
        else if (wr_con2)
        begin
            reference_select_r      <= pwdata_i[CON2_VCFG_LO +: 3];
            sequences_per_irq_r     <= pwdata_i[CON2_SMPI_LO +: 4];
            split_buffer_mode_r     <= pwdata_i[CON2_SPLIT_BUFFER_MODE];
            alternate_mux_sample_r  <= pwdata_i[CON2_ALTERNATE_MUX_SAMPLE];
        end
    end

    // Unavailable channel numbers are refused and the old choice stays
    assign new_a = pwdata_i[CHSEL_A_LO +: 4];
    assign new_b = pwdata_i[CHSEL_B_LO +: 4];

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            chan_a_r <= CHAN_RST;
            chan_b_r <= CHAN_RST;
        end
        else if (wr_chsel)
        begin
            if (CHANNEL_MASK[new_a]) chan_a_r <= new_a;
            if (CHANNEL_MASK[new_b]) chan_b_r <= new_b;
        end
    end

    // Sample/convert phase
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            phase_r <= PH_OFF;
        else if (ce_i)
        begin
            case (phase_r)
                PH_OFF:     if (run) phase_r <= PH_HOLD;
                PH_HOLD:    if (sw_start) phase_r <= PH_SAMPLE;
                PH_SAMPLE:  if (end_sample) phase_r <= PH_CONVERT;
                            else if (sw_abort && run) phase_r <= PH_HOLD;
                PH_CONVERT: if (complete)
                                phase_r <= auto_sample_start_r ? PH_SAMPLE : PH_HOLD;
                default:    phase_r <= PH_OFF;
            endcase
            if (!converter_on_r)
                phase_r <= PH_OFF;
        end
    end

    // Sampling time counter for the auto-convert source
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            sample_enable_cnt_r <= 16'h0000;
        else if (run)
            sample_enable_cnt_r <= sampling ? sample_enable_cnt_r + 16'h0001 : 16'h0000;
    end

    // Done flag; completion wins over a software write in the same cycle
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            done_r <= CON1_RST[CON1_DONE];
        else if (ce_i)
        begin
            if (!converter_on_r)
                done_r <= 1'b0;
            else if (complete)
                done_r <= 1'b1;
            else if (sw_start)
                done_r <= 1'b0;
            else if (wr_con1)
                done_r <= pwdata_i[CON1_DONE];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            conv_start_r <= 1'b0;
        else if (ce_i)
            conv_start_r <= end_sample;
    end

    // Result buffer; contents are wiped while the module is off
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < BUF_WORDS; i++)
                buf_r[i] <= '0;
        end
        else if (ce_i)
        begin
            if (!converter_on_r)
            begin
                for (int i = 0; i < BUF_WORDS; i++)
                    buf_r[i] <= '0;
            end
            else if (complete)
                buf_r[wr_idx] <= conv_data_i;
        end
    end

    // Sequence counting, fill pointer, half select, mux alternation
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            seq_cnt_r          <= 4'h0;
            wr_ptr_r           <= 4'h0;
            buffer_fill_half_r <= 1'b0;
            alt_phase_r        <= 1'b0;
            irq_r              <= 1'b0;
        end
        else if (ce_i)
        begin
            irq_r <= 1'b0;
            if (!converter_on_r)
            begin
                seq_cnt_r          <= 4'h0;
                wr_ptr_r           <= 4'h0;
                buffer_fill_half_r <= 1'b0;
                alt_phase_r        <= 1'b0;
            end
            else if (complete)
            begin
                alt_phase_r <= alternate_mux_sample_r & ~alt_phase_r;
                if (seq_cnt_r == sequences_per_irq_r)
                begin
                    seq_cnt_r          <= 4'h0;
                    wr_ptr_r           <= 4'h0;
                    irq_r              <= 1'b1;
                    buffer_fill_half_r <= buffer_fill_half_r ^ split_buffer_mode_r;
                end
                else
                begin
                    seq_cnt_r <= seq_cnt_r + 4'h1;
                    wr_ptr_r  <= wr_ptr_r + 4'h1;
                end
            end
        end
    end

    // Register read data, captured in the setup phase
    assign con1_word = {converter_on_r, 1'b0, converter_idle_stop_r, 3'h0, result_format_r,
                        trigger_source_select_r, 2'h0, auto_sample_start_r, sampling, done_r};
    assign con2_word = {reference_select_r, 5'h00, buffer_fill_half_r, 1'b0,
                        sequences_per_irq_r, split_buffer_mode_r, alternate_mux_sample_r};

    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (paddr_i == OFF_CON1)
            rd_word = {16'h0000, con1_word};
        else if (paddr_i == OFF_CON2)
            rd_word = {16'h0000, con2_word};
        else if (paddr_i == OFF_CHSEL)
            rd_word = {20'h00000, chan_b_r, 4'h0, chan_a_r};
        else if (mapped)
            rd_word = {16'h0000, fmt_word};
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            prdata_r <= 32'h0000_0000;
        else if (rd_setup)
            prdata_r <= rd_word;
    end

    // Front-end outputs
    assign conv_start_o         = conv_start_r;
    assign sample_hold_o        = sampling;
    assign converter_on_o       = converter_on_r;
    assign ref_plus_ext_o       = (reference_select_r == 3'h1) ||
                                  (reference_select_r == 3'h3);
    assign ref_minus_ext_o      = (reference_select_r == 3'h2) ||
                                  (reference_select_r == 3'h3);
    assign mux_b_select_o       = alt_phase_r;
    assign mux_channel_o        = alt_phase_r ? chan_b_r : chan_a_r;
    assign converter_irq_flag_o = irq_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_sw_end;
        run && sampling && sw_end && (trigger_source_select_r == TRIG_SW);
    endsequence

    sequence s_start_convert;
        (phase_r == PH_CONVERT) && conv_start_o;
    endsequence

    a_off_idle: assert property (ce_i && !converter_on_r |=> phase_r == PH_OFF)
        else $error("converter active while off");
    a_off_wipe: assert property (ce_i && !converter_on_r |=> buf_r[wr_idx] == '0)
        else $error("result kept after switch off");
    a_idle_halt: assert property (ce_i && converter_on_r && converter_idle_stop_r && idle_mode_i
                                  |=> $stable(phase_r) && !conv_start_o)
        else $error("converter ran in idle with stop set");
    a_fmt_sign: assert property (result_format_r == FMT_SINT
                                 |-> fmt_word[15:9] == {7{fmt_word[9]}})
        else $error("signed integer not sign extended");
    a_sw_convert: assert property (s_sw_end |=> s_start_convert)
        else $error("clearing sample bit did not convert");
    a_auto_convert: assert property (run && sampling && trigger_source_select_r == TRIG_AUTO
                                     && count_done |=> s_start_convert)
        else $error("internal counter did not convert");
    a_auto_restart: assert property (complete && auto_sample_start_r
                                     |=> sample_hold_o && done_r)
        else $error("sampling not restarted");
    a_manual_wait: assert property (ce_i && phase_r == PH_HOLD && !sw_start
                                    |=> !sample_hold_o)
        else $error("sampling began without software");
    a_irq_rate: assert property (converter_irq_flag_o
                                 |-> $past(seq_cnt_r) == $past(sequences_per_irq_r))
        else $error("interrupt at wrong sequence count");
    a_half_swap: assert property (complete && split_buffer_mode_r
                                  && seq_cnt_r == sequences_per_irq_r
                                  |=> buffer_fill_half_r != $past(buffer_fill_half_r))
        else $error("fill half did not swap");

endmodule // adcc_top

// *** verilog/adcc_pkg.sv ***
// Purpose: Shared constants and types for the converter sample/convert control block
// Assumes: APB register map with one 32-bit aligned word per register
// Notes:   Offsets, field positions, reset values and the default sampling count live here
package adcc_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CON1  = 8'h00;
    localparam logic [7:0] OFF_CON2  = 8'h04;
    localparam logic [7:0] OFF_CHSEL = 8'h08;
    localparam logic [7:0] OFF_BUF   = 8'h40;
    localparam logic [7:0] BUF_MASK  = 8'hC0;

    // Control register one fields
    localparam int CON1_ON      = 15;
    localparam int CON1_SIDL    = 13;
    localparam int CON1_FORM_LO = 8;
    localparam int CON1_SRC_LO  = 5;
    localparam int CON1_AUTO_SAMPLE_START    = 2;
    localparam int CON1_SAMPLE_ENABLE    = 1;
    localparam int CON1_DONE    = 0;

    // Control register two fields
    localparam int CON2_VCFG_LO = 13;
    localparam int CON2_BUFFER_FILL_HALF    = 7;
    localparam int CON2_SMPI_LO = 2;
    localparam int CON2_SPLIT_BUFFER_MODE    = 1;
    localparam int CON2_ALTERNATE_MUX_SAMPLE    = 0;

    // Channel select register fields
    localparam int CHSEL_A_LO = 0;
    localparam int CHSEL_B_LO = 8;

    // Reset values
    localparam logic [15:0] CON1_RST  = 16'h0000;
    localparam logic [15:0] CON2_RST  = 16'h0000;
    localparam logic [3:0]  CHAN_RST  = 4'h0;

    // Channels 0..5 and 10..12 exist
    localparam logic [15:0] CHANNEL_MASK = 16'h1C3F;

    // Sizes and counts
    localparam int unsigned RES_W              = 10;
    localparam int unsigned BUF_WORDS          = 16;
    localparam int unsigned AUTO_SAMPLE_CYCLES = 16;

    typedef enum logic [1:0] {
        FMT_INT     = 2'h0,
        FMT_SINT    = 2'h1,
        FMT_FRAC    = 2'h2,
        FMT_SFRAC   = 2'h3
    } adcc_fmt_t;

    typedef enum logic [2:0] {
        TRIG_SW     = 3'h0,
        TRIG_PIN    = 3'h1,
        TRIG_TIMER  = 3'h2,
        TRIG_CHARGE = 3'h6,
        TRIG_AUTO   = 3'h7
    } adcc_trig_t;

    typedef enum logic [1:0] {
        PH_OFF,
        PH_HOLD,
        PH_SAMPLE,
        PH_CONVERT
    } adcc_phase_t;

endpackage

// *** verilog/adcc_result_fmt.sv ***
// Purpose: Presents a raw result word in one of four formats
// Assumes: Raw result is an offset-binary 10-bit code
// Notes:   Pure combinational; formatting happens on read
`timescale 1ns/100ps
module adcc_result_fmt
    import adcc_pkg::*;
(
    // Format select and data
    input  wire logic [1:0]       form_i,
    input  wire logic [RES_W-1:0] raw_i,
    output logic      [15:0]      word_o
);
    import adcc_pkg::*;

    logic [RES_W-1:0] sgn_code;

    // Midscale becomes zero for signed forms
    assign sgn_code = {~raw_i[RES_W-1], raw_i[RES_W-2:0]};

    always_comb
    begin
        case (form_i)
            FMT_INT:   word_o = {6'h00, raw_i};
            FMT_SINT:  word_o = {{6{sgn_code[RES_W-1]}}, sgn_code};
            FMT_FRAC:  word_o = {raw_i, 6'h00};
            FMT_SFRAC: word_o = {sgn_code, 6'h00};
            default:   word_o = 16'h0000;
        endcase
    end

endmodule // adcc_result_fmt

// *** verilog/adcc_trig_sel.sv ***
// Purpose: Chooses the event that ends sampling and starts conversion
// Assumes: Trigger inputs are synchronous to clk_i
// Notes:   Reserved codes never fire, so sampling runs until software stops it
`timescale 1ns/100ps
module adcc_trig_sel
    import adcc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    // Selection and sources
    input  wire logic [2:0] src_i,
    input  wire logic       sw_end_i,
    input  wire logic       pin_i,
    input  wire logic       timer_i,
    input  wire logic       charge_i,
    input  wire logic       count_done_i,
    // Result
    output logic            end_o
);
    import adcc_pkg::*;

    logic pin_prev_r;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pin_prev_r <= 1'b0;
        else if (ce_i)
            pin_prev_r <= pin_i;
    end

    always_comb
    begin
        case (src_i)
            TRIG_SW:     end_o = sw_end_i;
            TRIG_PIN:    end_o = pin_i & ~pin_prev_r;
            TRIG_TIMER:  end_o = timer_i;
            TRIG_CHARGE: end_o = charge_i;
            TRIG_AUTO:   end_o = count_done_i;
            default:     end_o = 1'b0;
        endcase
    end

endmodule // adcc_trig_sel

// *** bench/adcc_front_model.sv ***
// Purpose: Analog front end stand-in that answers each conversion start
// Assumes: One conversion in flight at a time
// Notes:   Data line toggles while not valid, so a stale code is never read as fresh
`timescale 1ns/100ps
module adcc_front_model
#(
    parameter int DELAY = 3
)
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // Conversion handshake
    input  wire logic       conv_start_i,
    input  wire logic [9:0] code_i,
    output logic            conv_ready_o,
    output logic      [9:0] conv_data_o
);
    int cnt;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt          <= 0;
            conv_ready_o <= 1'b0;
            conv_data_o  <= 10'h3FF;
        end
        else
        begin
            cnt          <= conv_start_i ? DELAY : (cnt > 0 ? cnt - 1 : 0);
            conv_ready_o <= (cnt == 1);
            conv_data_o  <= (cnt == 1) ? code_i : ~conv_data_o;
        end
    end
endmodule // adcc_front_model

// *** bench/adcc_top_tb.sv ***
// Purpose: Self-checking bench for the converter sample/convert control
// Assumes: Zero-wait APB slave, front end model answers starts
// Notes:   Short auto-sample count keeps the run brief
`timescale 1ns/100ps
module adc_sample_convert_control_tb;
    import adcc_pkg::*;
    logic        clk_i;
    logic        rst_n_i;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic        pin = 1'b0;
    logic        tmr = 1'b0;
    logic        chg = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready, perr, err, conv_ready, conv_start, sh, on, rp, rm, irq;
    logic        idle = 1'b0;
    logic        mb;
    logic [3:0]  mch;
    logic [9:0]  cdata;
    logic [9:0]  code = 10'h155;
    logic [2:0]  ev;
    int          n_errors = 0;
    int          checks_done = 0;
    int          n_irq = 0;

    assign ev = {pready, irq, conv_start};

    adcc_top #(.SAMPLE_CYCLES(4)) uut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(perr), .idle_mode_i(idle),
        .external_irq_pin_zero_i(pin), .timer_three_match_i(tmr),
        .charge_measure_unit_event_i(chg), .conv_ready_i(conv_ready), .conv_data_i(cdata),
        .conv_start_o(conv_start), .sample_hold_o(sh), .converter_on_o(on),
        .ref_plus_ext_o(rp), .ref_minus_ext_o(rm), .mux_channel_o(mch), .mux_b_select_o(mb),
        .converter_irq_flag_o(irq));

    adcc_front_model #(.DELAY(3)) front (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .conv_start_i(conv_start), .code_i(code),
        .conv_ready_o(conv_ready), .conv_data_o(cdata));

    // Interrupt pulses seen so far
    always @(posedge clk_i)
        n_irq <= n_irq + int'(irq);

    task automatic summarize();
        if (n_errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Bounded wait: 0 conversion start, 1 interrupt, 2 bus ready
    task automatic wait_hi(input int sel);
        for (int i = 0; i < 100; i++)
        begin
            @(posedge clk_i);
            if (ev[sel] === 1'b1)
                return;
        end
        n_errors++;
        summarize();
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_i);
        pen <= 1'b1;
        wait_hi(2);
        rd   = prdata;
        err  = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask

    // Reset values, reference switches and an unmapped address
    task automatic regs();
        logic [1:0] ext [3] = '{2'b00, 2'b10, 2'b01};
        apb(0, OFF_CON1, 0);
        chk(rd, CON1_RST);
        apb(0, OFF_CON2, 0);
        chk(rd, CON2_RST);
        for (int r = 0; r < 3; r++)
        begin
            apb(1, OFF_CON2, 32'(r << 13));
            apb(0, OFF_CON2, 0);
            chk(rd, 32'(r << 13));
            chk({rp, rm}, ext[r]);
        end
        apb(0, 8'h10, 0);
        chk(err, 1);
    endtask

    // Software ends sampling, then every format presents the same code
    task automatic sw_trigger();
        logic [15:0] exp [4] = '{16'h0155, 16'hFF55, 16'h5540, 16'hD540};
        apb(1, OFF_CON1, 32'h8000);
        apb(1, OFF_CON1, 32'h8002);
        apb(0, OFF_CON1, 0);
        chk(rd, 32'h8002);
        chk({on, sh}, 2'b11);
        apb(1, OFF_CON1, 32'h8000);
        wait_hi(0);
        wait_hi(1);
        @(posedge clk_i);
        chk(irq, 0);
        apb(0, OFF_CON1, 0);
        chk(rd, 32'h8001);
        for (int f = 0; f < 4; f++)
        begin
            apb(1, OFF_CON1, 32'h8000 | 32'(f << 8));
            apb(0, OFF_BUF, 0);
            chk(rd, exp[f]);
        end
    endtask

    // Each external event ends sampling; reserved codes are never used
    task automatic ext_trigger();
        logic [2:0] src [3] = '{3'h1, 3'h2, 3'h6};
        for (int k = 0; k < 3; k++)
        begin
            apb(1, OFF_CON1, 32'h8000 | 32'(src[k]) << 5);
            apb(1, OFF_CON1, 32'h8002 | 32'(src[k]) << 5);
            @(posedge clk_i);
            {chg, tmr, pin} <= 3'b001 << k;
            @(posedge clk_i);
            {chg, tmr} <= 2'b00;
            wait_hi(0);
            chk(sh, 0);
            pin <= 1'b0;
            wait_hi(1);
        end
    endtask

    // Idle with stop set freezes sampling; leaving idle lets it convert
    task automatic idle_stop();
        apb(1, OFF_CON1, 32'hA002);
        idle <= 1'b1;
        apb(1, OFF_CON1, 32'hA000);
        repeat (4) @(posedge clk_i);
        chk({sh, conv_start}, 2'b10);
        idle <= 1'b0;
        apb(1, OFF_CON1, 32'hA000);
        wait_hi(0);
        wait_hi(1);
    endtask

    // Channel choice, mux alternation, split buffer, two sequences per interrupt
    task automatic chan_alt();
        int n0;
        apb(1, OFF_CHSEL, 32'h0A05);
        apb(1, OFF_CHSEL, 32'h0907);
        apb(0, OFF_CHSEL, 0);
        chk(rd, 32'h0A05);
        apb(1, OFF_CON2, 32'h0007);
        chk(mch, 4'h5);
        n0 = n_irq;
        for (int s = 0; s < 2; s++)
        begin
            apb(1, OFF_CON1, 32'h8002);
            apb(1, OFF_CON1, 32'h8000);
            wait_hi(0);
            repeat (6) @(posedge clk_i);
            chk({mb, mch}, s ? 5'h05 : 5'h1A);
            chk(n_irq - n0, s);
        end
        apb(0, OFF_CON2, 0);
        chk(rd, 32'h0087);
    endtask

    // Counter ends sampling, auto-start resumes it, switching off clears results
    task automatic auto_mode();
        apb(1, OFF_CON1, 32'h80E6);
        wait_hi(0);
        wait_hi(1);
        chk(sh, 1);
        wait_hi(0);
        apb(1, OFF_CON1, 32'h0000);
        apb(0, OFF_BUF, 0);
        chk(rd, 0);
        chk(on, 0);
    endtask

    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    initial
    begin
        rst_n_i = 1'b0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        regs();
        sw_trigger();
        ext_trigger();
        idle_stop();
        chan_alt();
        auto_mode();
        summarize();
    end
endmodule // adc_sample_convert_control_tb
